// file: logic/osc_trim_consts.vh
// Overview of operation
// [R1] Sweep interval zero disables spread spectrum; programmed fine code passes unchanged.
// [R2] Amplitude select 11/10/01/00 gives peak deviation 32/16/8/4.
// [R3] Applied fine code is programmed code plus offset, saturated to 0..255.
// [R4] Sweep offset updates once every N oscillator cycles, N the interval field.
// [R5] A full sweep lasts 4 * N * (2 * amplitude + 1) oscillator cycles; the code's sweep lasts 4 * N * peak deviation cycles.
// [R6] Offset moves as a triangle, one per update, reversing at each extreme.
// [R7] Coarse trim field drives the oscillator band select directly.
// [R8] Larger fine code gives lower frequency, monotonically; code drives the oscillator.
// [R9] Supply trim register at a000 is 8-bit read/write, resets to all ones.
// [R10] Register a001 holds interval 7:4, amplitude 3:2, coarse 1:0, resets 01.
// [R11] Fine trim register at a002 holds the 8-bit code, resets to 8e.
// [R12] Every reset returns trim registers to defaults; software reloads calibration.
// [R13] Software calibrates with coarse 01, fine 00, ff, 7f, then binary search.
// [R14] Main regulator in normal, reduced-speed and stop; back-up regulator in sleep.
// [R15] Regulator selection follows mode changes with no software action.
// [R16] Power-on reset condition comes from the back-up regulator.
// [R17] After sleep exit, about 10 ms pass before main regulator is trusted.
// [R18] Internal oscillator enabled in every mode except stop.
// [R19] Oscillator gating is glitch free; output trusted within 10 cycles.
// [R20] Crystal oscillator disabled after power-on and after any reset.
// [R21] Software waits tens of milliseconds after crystal enable before switching.
// [R22] Crystal oscillator has three parallel inverter stages, each separately enabled.
// [R23] Crystal drive: 0000 off, 0001 low, 0011 medium, 0111 high, 1xxx bypass.
`ifndef OSC_TRIM_CONSTS_VH
`define OSC_TRIM_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_SUPPLY_TRIM 16'ha000
`define ADDR_COARSE_SWEEP 16'ha001
`define ADDR_FINE_TRIM 16'ha002
`define ADDR_STATUS 16'ha003
`define ADDR_APPLIED_FINE 16'ha004
`define ADDR_CRYSTAL_DRIVE 16'ha007

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SUPPLY_TRIM 8'hff
`define RST_COARSE_SWEEP 8'h01
`define RST_FINE_TRIM 8'h8e
`define RST_CRYSTAL_DRIVE 4'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FLD_INTERVAL_HI 7
`define FLD_INTERVAL_LO 4
`define FLD_AMP_HI 3
`define FLD_AMP_LO 2
`define FLD_COARSE_HI 1
`define FLD_COARSE_LO 0
`define FLD_BYPASS 3

// ----------------------------------------
// Power modes
// ----------------------------------------
`define MODE_NORMAL 2'h0
`define MODE_REDUCED 2'h1
`define MODE_STOP 2'h2
`define MODE_SLEEP 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_FREQ_KHZ 125000
`define MAIN_REG_SETTLE_MS 10
`define OSC_SETTLE_CYCLES 10

`endif

// file: logic/osc_trim_spread_spectrum_ctrl.v
`timescale 1ns/100ps
`include "osc_trim_consts.vh"

module osc_trim_spread_spectrum_ctrl #(
    parameter MAIN_SETTLE_CYCLES = `MAIN_REG_SETTLE_MS * `CLK_FREQ_KHZ,
    parameter ADDR_WIDTH = 16,
    parameter DATA_WIDTH = 8
)
(
    input wire ref_clk,
    input wire reset_n,
    input wire [ADDR_WIDTH-1:0] regAddr,
    input wire [DATA_WIDTH-1:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [DATA_WIDTH-1:0] regRdData_r,
    input wire [1:0] powerMode,
    input wire backupRegOk,
    output reg [7:0] supplyTrim_r,
    output reg mainRegSel_r,
    output reg backupRegSel_r,
    output reg mainRegReady_r,
    output reg powerOnReset_r,
    output reg oscEnable_r,
    output reg oscStable_r,
    output reg [1:0] coarseBand_r,
    output reg [7:0] appliedFineCode_r,
    output reg [2:0] crystalStageEn_r,
    output reg crystalBypass_r
);

// ----------------------------------------
// Local helpers
// ----------------------------------------
// Settle counts are cut to their counter widths on purpose
localparam [31:0] SETTLE_LAST_W = MAIN_SETTLE_CYCLES - 1;
localparam [20:0] SETTLE_LAST = SETTLE_LAST_W[20:0];
localparam [31:0] OSC_SETTLE_W = `OSC_SETTLE_CYCLES - 1;
localparam [3:0] OSC_SETTLE_LAST = OSC_SETTLE_W[3:0];

// Peak deviation for each amplitude select code
function [6:0] peakOf;
    input [1:0] sel;
    begin
        case (sel)
            2'h3: peakOf = 7'h20; // R2
            2'h2: peakOf = 7'h10; // R2
            2'h1: peakOf = 7'h08; // R2
            default: peakOf = 7'h04; // R2
        endcase
    end
endfunction

// Crystal drive code to stage enables; unlisted codes pass bits through
function [2:0] stagesOf;
    input [3:0] drive;
    begin
        if (drive[`FLD_BYPASS])
        begin
            stagesOf = 3'h0;
        end
        else
        begin
            stagesOf = drive[2:0];
        end
    end
endfunction

// ----------------------------------------
// Register storage
// ----------------------------------------
reg [7:0] coarseSweep_r;
reg [7:0] fineTrim_r;
reg [3:0] crystalDrive_r;

wire [3:0] sweepStepInterval;
wire [1:0] sweepAmplitudeSel;
wire [1:0] coarseBandSel;

assign sweepStepInterval = coarseSweep_r[`FLD_INTERVAL_HI:`FLD_INTERVAL_LO];
assign sweepAmplitudeSel = coarseSweep_r[`FLD_AMP_HI:`FLD_AMP_LO];
assign coarseBandSel = coarseSweep_r[`FLD_COARSE_HI:`FLD_COARSE_LO];

// All trim state goes back to defaults on any reset, so calibration
// values must be reloaded by software afterwards
always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        supplyTrim_r <= `RST_SUPPLY_TRIM; // R9 R12
        coarseSweep_r <= `RST_COARSE_SWEEP; // R10 R12
        fineTrim_r <= `RST_FINE_TRIM; // R11 R12
        crystalDrive_r <= `RST_CRYSTAL_DRIVE; // R20
    end
    else if (regWrite)
    begin
        case (regAddr)
            `ADDR_SUPPLY_TRIM:
            begin
                supplyTrim_r <= regWrData; // R9
            end
            `ADDR_COARSE_SWEEP:
            begin
                coarseSweep_r <= regWrData; // R10
            end
            `ADDR_FINE_TRIM:
            begin
                fineTrim_r <= regWrData; // R11
            end
            `ADDR_CRYSTAL_DRIVE:
            begin
                crystalDrive_r <= regWrData[3:0]; // R23
            end
            default:
            begin
                supplyTrim_r <= supplyTrim_r;
            end
        endcase
    end
end

// ----------------------------------------
// Read port
// ----------------------------------------
reg [7:0] rdNxt;

// Fine trim is write-only and reads as zero
always @*
begin
    rdNxt = 8'h00;
    case (regAddr)
        `ADDR_SUPPLY_TRIM: rdNxt = supplyTrim_r; // R9
        `ADDR_COARSE_SWEEP: rdNxt = coarseSweep_r; // R10
        `ADDR_STATUS: rdNxt = {3'h0, powerOnReset_r, oscStable_r, oscEnable_r, mainRegReady_r, mainRegSel_r};
        `ADDR_APPLIED_FINE: rdNxt = appliedFineCode_r;
        `ADDR_CRYSTAL_DRIVE: rdNxt = {4'h0, crystalDrive_r};
        default: rdNxt = 8'h00;
    endcase
end

always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        regRdData_r <= 8'h00;
    end
    else if (regRead)
    begin
        regRdData_r <= rdNxt;
    end
    else
    begin
        regRdData_r <= 8'h00;
    end
end

// ----------------------------------------
// Spread spectrum sweep
// ----------------------------------------
reg [3:0] stepCount_r;
reg signed [6:0] sweepOffset_r;
reg sweepUp_r;

wire sweepOn;
wire stepDue;
wire signed [6:0] peak;

assign sweepOn = (sweepStepInterval != 4'h0); // R1
assign stepDue = sweepOn && (stepCount_r >= sweepStepInterval - 4'h1); // R4
assign peak = peakOf(sweepAmplitudeSel); // R2

// One offset step per N oscillator cycles, so a full triangle of
// 4 * peak steps sets the sweep period; a change of amplitude while
// beyond the new peak just turns the sweep back towards zero
always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        stepCount_r <= 4'h0;
        sweepOffset_r <= 7'sd0;
        sweepUp_r <= 1'b1;
    end
    else if (!sweepOn)
    begin
        stepCount_r <= 4'h0; // R1
        sweepOffset_r <= 7'sd0; // R1
        sweepUp_r <= 1'b1;
    end
    else if (stepDue)
    begin
        stepCount_r <= 4'h0; // R4 R5
        if (sweepUp_r)
        begin
            if (sweepOffset_r >= peak)
            begin
                sweepUp_r <= 1'b0; // R6
                sweepOffset_r <= sweepOffset_r - 7'sd1;
            end
            else
            begin
                sweepOffset_r <= sweepOffset_r + 7'sd1; // R6
            end
        end
        else
        begin
            if (sweepOffset_r <= -peak)
            begin
                sweepUp_r <= 1'b1; // R6
                sweepOffset_r <= sweepOffset_r + 7'sd1;
            end
            else
            begin
                sweepOffset_r <= sweepOffset_r - 7'sd1; // R6
            end
        end
    end
    else
    begin
        stepCount_r <= stepCount_r + 4'h1; // R4
    end
end

// ----------------------------------------
// Applied trim codes
// ----------------------------------------
wire signed [9:0] sumWide;
reg [7:0] appliedNxt;

assign sumWide = $signed({2'b00, fineTrim_r}) + {{3{sweepOffset_r[6]}}, sweepOffset_r}; // R3

// Clipping near the ends flattens the sweep; keep the programmed
// code at least one peak away from 0 and 255 for a clean triangle
always @*
begin
    appliedNxt = fineTrim_r;
    if (!sweepOn)
    begin
        appliedNxt = fineTrim_r; // R1
    end
    else if (sumWide < 10'sd0)
    begin
        appliedNxt = 8'h00; // R3
    end
    else if (sumWide > 10'sd255)
    begin
        appliedNxt = 8'hff; // R3
    end
    else
    begin
        appliedNxt = sumWide[7:0]; // R3
    end
end

// Code polarity is kept as is: a larger code slows the oscillator
always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        appliedFineCode_r <= `RST_FINE_TRIM;
        coarseBand_r <= 2'h1;
    end
    else
    begin
        appliedFineCode_r <= appliedNxt; // R8
        coarseBand_r <= coarseBandSel; // R7
    end
end

// ----------------------------------------
// Regulator selection
// ----------------------------------------
reg [20:0] settleCount_r;
reg settling_r;
reg wasSleep_r;

wire inSleep;

assign inSleep = (powerMode == `MODE_SLEEP);

always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        mainRegSel_r <= 1'b1;
        backupRegSel_r <= 1'b0;
        wasSleep_r <= 1'b0;
    end
    else
    begin
        mainRegSel_r <= !inSleep; // R14 R15
        backupRegSel_r <= inSleep; // R14 R15
        wasSleep_r <= inSleep;
    end
end

// Ready drops on entering sleep and returns only after the settle
// count has run out following the exit
always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        settleCount_r <= 21'h0;
        settling_r <= 1'b0;
        mainRegReady_r <= 1'b1;
    end
    else if (inSleep)
    begin
        settleCount_r <= 21'h0;
        settling_r <= 1'b0;
        mainRegReady_r <= 1'b0;
    end
    else if (wasSleep_r)
    begin
        settleCount_r <= 21'h0; // R17
        settling_r <= 1'b1;
        mainRegReady_r <= 1'b0;
    end
    else if (settling_r)
    begin
        if (settleCount_r >= SETTLE_LAST)
        begin
            settling_r <= 1'b0;
            mainRegReady_r <= 1'b1; // R17
        end
        else
        begin
            settleCount_r <= settleCount_r + 21'h1; // R17
        end
    end
end

// Power-on reset request follows the back-up regulator good level
always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        powerOnReset_r <= 1'b1;
    end
    else
    begin
        powerOnReset_r <= !backupRegOk; // R16
    end
end

// ----------------------------------------
// Internal oscillator gating
// ----------------------------------------
reg [3:0] oscCount_r;

// Enable comes from one flop so the analog gate sees a single clean
// edge; stable is withheld for the settle cycles after each enable
always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        oscEnable_r <= 1'b1;
        oscStable_r <= 1'b0;
        oscCount_r <= 4'h0;
    end
    else
    begin
        oscEnable_r <= (powerMode != `MODE_STOP); // R18 R19
        if (!oscEnable_r)
        begin
            oscStable_r <= 1'b0;
            oscCount_r <= 4'h0;
        end
        else if (oscCount_r >= OSC_SETTLE_LAST)
        begin
            oscStable_r <= 1'b1; // R19
        end
        else
        begin
            oscCount_r <= oscCount_r + 4'h1; // R19
        end
    end
end

// ----------------------------------------
// Crystal oscillator drive
// ----------------------------------------
always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        crystalStageEn_r <= 3'h0; // R20
        crystalBypass_r <= 1'b0; // R20
    end
    else
    begin
        crystalStageEn_r <= stagesOf(crystalDrive_r); // R22 R23
        crystalBypass_r <= crystalDrive_r[`FLD_BYPASS]; // R23
    end
end

endmodule // osc_trim_spread_spectrum_ctrl

// file: verification/osc_trim_checker_asserts.sv
`timescale 1ns/100ps
module osc_trim_checker (
    input wire ref_clk,
    input wire reset_n,
    input wire [15:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regRdData_r,
    input wire [1:0] powerMode,
    input wire backupRegOk,
    input wire [7:0] supplyTrim_r,
    input wire mainRegSel_r,
    input wire backupRegSel_r,
    input wire mainRegReady_r,
    input wire powerOnReset_r,
    input wire oscEnable_r,
    input wire oscStable_r,
    input wire [1:0] coarseBand_r,
    input wire [7:0] appliedFineCode_r,
    input wire [2:0] crystalStageEn_r,
    input wire crystalBypass_r
);
// ----------------------------------------
// Shadow of the trim registers
// ----------------------------------------
reg [7:0] fine_r;
reg [7:0] ctrl_r;
reg [1:0] quiet_r;
wire wrCtl = regWrite && regAddr == 16'ha001;
wire wrFine = regWrite && regAddr == 16'ha002;
wire [8:0] pk = 9'h4 << ctrl_r[3:2];
wire [8:0] lo = (fine_r < pk) ? 9'h0 : fine_r - pk;
wire [8:0] hi = (fine_r + pk > 9'hff) ? 9'hff : fine_r + pk;
wire sweep = quiet_r == 2'h3 && ctrl_r[7:4] != 4'h0;
// Sweep checks wait three edges after a trim write, so the jump it causes is not judged
always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
        fine_r <= 8'h8e;
        ctrl_r <= 8'h01;
        quiet_r <= 2'h0;
    end
    else
    begin
        fine_r <= wrFine ? regWrData : fine_r;
        ctrl_r <= wrCtl ? regWrData : ctrl_r;
        quiet_r <= (wrCtl || wrFine) ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
    end
reg [3:0] enCnt_r;
// Cycles the oscillator enable has been seen high, held at its ceiling
always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
        enCnt_r <= 4'h0;
    else
        enCnt_r <= !oscEnable_r ? 4'h0 : enCnt_r + {3'h0, enCnt_r != 4'hf};
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!reset_n);
sequence ctlWrite;
    regWrite && regAddr == 16'ha001;
endsequence
sequence ctlIdle;
    !(regWrite && regAddr == 16'ha001);
endsequence
a_coarse_band: assert property (ctlWrite ##1 ctlIdle |=>
    coarseBand_r == $past(regWrData[1:0], 2)) else $error("coarse band mismatch");
a_supply_write: assert property (regWrite && regAddr == 16'ha000 |=>
    supplyTrim_r == $past(regWrData)) else $error("supply trim not written");
a_write_only: assert property (regRead && regAddr == 16'ha002 |=>
    regRdData_r == 8'h00) else $error("fine trim readable");
a_osc_mode: assert property ($past(reset_n) |->
    oscEnable_r == ($past(powerMode) != 2'h2)) else $error("osc enable wrong");
a_reg_mode: assert property ($past(reset_n) |-> mainRegSel_r ==
    ($past(powerMode) != 2'h3) && backupRegSel_r == !mainRegSel_r) else $error("regulator select wrong");
a_sleep_ready: assert property ($past(reset_n) && $past(powerMode) == 2'h3 |->
    !mainRegReady_r) else $error("main ready in sleep");
a_por_follow: assert property ($past(reset_n) |->
    powerOnReset_r == !$past(backupRegOk)) else $error("power-on request wrong");
a_osc_settle: assert property (oscEnable_r && enCnt_r >= 4'ha |->
    oscStable_r) else $error("osc not stable in time");
a_fixed_fine: assert property (quiet_r == 2'h3 && ctrl_r[7:4] == 4'h0 |->
    appliedFineCode_r == fine_r) else $error("fixed fine code wrong");
a_clamp_range: assert property (sweep |->
    appliedFineCode_r >= lo && appliedFineCode_r <= hi) else $error("sweep out of range");
a_sweep_step: assert property (sweep |-> (appliedFineCode_r - $past(appliedFineCode_r))
    inside {8'h00, 8'h01, 8'hff}) else $error("sweep step too big");
a_hold_interval: assert property (sweep && ctrl_r[7:4] > 4'h1 &&
    $changed(appliedFineCode_r) |=> $stable(appliedFineCode_r)) else $error("sweep too fast");
a_bypass_off: assert property (crystalBypass_r |->
    crystalStageEn_r == 3'h0) else $error("stages on in bypass");
endmodule // osc_trim_checker

bind osc_trim_spread_spectrum_ctrl osc_trim_checker chk (.ref_clk, .reset_n, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData_r, .powerMode, .backupRegOk, .supplyTrim_r, .mainRegSel_r,
    .backupRegSel_r, .mainRegReady_r, .powerOnReset_r, .oscEnable_r, .oscStable_r, .coarseBand_r,
    .appliedFineCode_r, .crystalStageEn_r, .crystalBypass_r);

// file: verification/tb_osc_trim_spread_spectrum_ctrl.sv
`timescale 1ns/100ps
module tb_osc_trim_spread_spectrum_ctrl;
reg ref_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, backupRegOk = 1'b1;
reg [15:0] regAddr = 16'h0;
reg [7:0] regWrData = 8'h0;
reg [1:0] powerMode = 2'h0;
wire [7:0] regRdData_r, supplyTrim_r, appliedFineCode_r;
wire [1:0] coarseBand_r;
wire [2:0] crystalStageEn_r;
wire mainRegSel_r, backupRegSel_r, mainRegReady_r, powerOnReset_r, oscEnable_r, oscStable_r, crystalBypass_r;
int badCount = 0, checks = 0, cycles = 0, n = 0, i, a, p;
reg [7:0] lo, hi, mn, mx, prev, v;
reg [7:0] fineTab [0:5] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h02, 8'hfd};
reg [3:0] xTab [0:4] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};

// Settle count cut short so the sleep exit fits in a short run
osc_trim_spread_spectrum_ctrl #(.MAIN_SETTLE_CYCLES(20)) uut (.ref_clk, .reset_n, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData_r, .powerMode, .backupRegOk, .supplyTrim_r, .mainRegSel_r,
    .backupRegSel_r, .mainRegReady_r, .powerOnReset_r, .oscEnable_r, .oscStable_r, .coarseBand_r,
    .appliedFineCode_r, .crystalStageEn_r, .crystalBypass_r);

initial
begin
    forever #4 ref_clk = ~ref_clk;
end

// ----------------------------------------
// Bus and compare tasks
// ----------------------------------------
task chk(input [7:0] got, input [7:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
        badCount = badCount + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task chkb(input got, input exp);
    chk({7'h0, got}, {7'h0, exp});
endtask
task cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
endtask
task wr(input [15:0] ad, input [7:0] d);
    @(posedge ref_clk);
    regAddr <= ad;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
endtask
task rd(input [15:0] ad, input [7:0] exp);
    @(posedge ref_clk);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    chk(regRdData_r, exp);
endtask
task fin;
    n = n + 1;
    $display("test %0d done", n);
endtask
task conclude;
    $display("checks=%0d bad_count=%0d", checks, badCount);
    if (badCount == 0 && checks > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask

always @(posedge ref_clk)
begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
        badCount = badCount + 1;
        conclude;
    end
end

// ----------------------------------------
// Tests
// ----------------------------------------
initial
begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(16'ha000, 8'hff);
    rd(16'ha001, 8'h01);
    rd(16'ha002, 8'h00);
    rd(16'ha007, 8'h00);
    rd(16'ha005, 8'h00);
    chk(appliedFineCode_r, 8'h8e);
    chk({6'h0, coarseBand_r}, 8'h01);
    fin;
    wr(16'ha000, 8'h3c);
    rd(16'ha000, 8'h3c);
    chk(supplyTrim_r, 8'h3c);
    wr(16'ha001, 8'h0e);
    cyc(2);
    chk({6'h0, coarseBand_r}, 8'h02);
    rd(16'ha001, 8'h0e);
    wr(16'ha002, 8'hf0);
    cyc(3);
    chk(appliedFineCode_r, 8'hf0);
    rd(16'ha004, 8'hf0);
    rd(16'ha002, 8'h00);
    wr(16'ha001, 8'h01);
    for (i = 0; i < 3; i++)
    begin
        v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'h7f;
        wr(16'ha002, v);
        cyc(2);
        chk(appliedFineCode_r, v);
    end
    chk({6'h0, coarseBand_r}, 8'h01);
    fin;
    wr(16'ha002, 8'h80);
    wr(16'ha001, 8'h31);
    cyc(4);
    v = 8'h0;
    prev = appliedFineCode_r;
    repeat (60)
    begin
        cyc(1);
        v = v + (appliedFineCode_r !== prev);
        prev = appliedFineCode_r;
    end
    chk(v, 8'h14);
    for (i = 0; i < 6; i++)
    begin
        a = (i < 4) ? i : 3;
        p = 4 << a;
        wr(16'ha002, fineTab[i]);
        wr(16'ha001, {4'h1, a[1:0], 2'h1});
        lo = (fineTab[i] < p) ? 8'h00 : fineTab[i] - p;
        hi = (fineTab[i] + p > 255) ? 8'hff : fineTab[i] + p;
        mn = 8'hff;
        mx = 8'h00;
        cyc(2);
        repeat (4 * p + 8)
        begin
            cyc(1);
            mn = (appliedFineCode_r < mn) ? appliedFineCode_r : mn;
            mx = (appliedFineCode_r > mx) ? appliedFineCode_r : mx;
        end
        chk(mn, lo);
        chk(mx, hi);
    end
    fin;
    for (i = 0; i < 4; i++)
    begin
        @(posedge ref_clk);
        powerMode <= i[1:0];
        cyc(2);
        chkb(mainRegSel_r, i != 3);
        chkb(backupRegSel_r, i == 3);
        chkb(oscEnable_r, i != 2);
    end
    @(posedge ref_clk);
    powerMode <= 2'h0;
    cyc(12);
    chkb(mainRegReady_r, 1'b0);
    cyc(20);
    chkb(mainRegReady_r, 1'b1);
    @(posedge ref_clk);
    powerMode <= 2'h2;
    cyc(3);
    chkb(oscStable_r, 1'b0);
    @(posedge ref_clk);
    powerMode <= 2'h0;
    cyc(4);
    chkb(oscStable_r, 1'b0);
    cyc(10);
    chkb(oscStable_r, 1'b1);
    rd(16'ha003, 8'h0f);
    @(posedge ref_clk);
    backupRegOk <= 1'b0;
    cyc(2);
    chkb(powerOnReset_r, 1'b1);
    @(posedge ref_clk);
    backupRegOk <= 1'b1;
    cyc(2);
    chkb(powerOnReset_r, 1'b0);
    fin;
    for (i = 0; i < 5; i++)
    begin
        wr(16'ha007, {4'h0, xTab[i]});
        cyc(2);
        chk({5'h0, crystalStageEn_r}, xTab[i][3] ? 8'h00 : {5'h0, xTab[i][2:0]});
        chkb(crystalBypass_r, xTab[i][3]);
        rd(16'ha007, {4'h0, xTab[i]});
    end
    fin;
    wr(16'ha000, 8'h11);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(16'ha000, 8'hff);
    rd(16'ha001, 8'h01);
    chk(appliedFineCode_r, 8'h8e);
    chkb(crystalBypass_r, 1'b0);
    rd(16'ha007, 8'h00);
    fin;
    conclude;
end
endmodule // tb_osc_trim_spread_spectrum_ctrl
